/* common/tiopd_pkg.sv */
// package for the terminal i/o port decoder: port addresses, fields, timing
// assumes a 100 MHz clock and an 8-bit i/o address space
package tiopd_pkg;
  // i/o port addresses (low address byte)
  localparam logic [7:0] TIOPD_CFG_RAM_TOP = 8'h7F;
  localparam logic [7:0] TIOPD_KEY_STATE_READ = 8'h80;
  localparam logic [7:0] TIOPD_INTERRUPT_MASK_LATCH = 8'h88;
  localparam logic [7:0] TIOPD_SYSTEM_STATUS_READ = 8'h90;
  localparam logic [7:0] TIOPD_PRINTER_DATA_PORT = 8'h98;
  localparam logic [7:0] TIOPD_SERIAL_ADAPTER_WINDOW = 8'hA0;
  localparam logic [7:0] TIOPD_MODEM_LATCH_PORT = 8'hA8;
  localparam logic [7:0] TIOPD_KEYBOARD_DISPLAY_CONTROL = 8'hB8;
  // each decoded group spans eight ports
  localparam logic [7:0] TIOPD_GROUP_MASK = 8'hF8;
  // rom space: six 8k blocks from 0000h, block index is a15..a13
  localparam int TIOPD_ROM_BLOCKS = 6;
  localparam logic [2:0] TIOPD_ROM_LAST_BLOCK = 3'h5;
  // serial adapter window: bit 2 picks write group
  localparam int TIOPD_SER_RW_BIT = 2;
  // keyboard/display control fields
  localparam int TIOPD_KBD_COL_LSB = 0;
  localparam int TIOPD_KBD_BELL_BIT = 4;
  localparam int TIOPD_KBD_ENH_BIT = 5;
  localparam int TIOPD_KBD_BLINK_BIT = 6;
  // modem latch fields
  localparam int TIOPD_MDM_DISC_BIT = 0;
  // system status bit positions
  localparam int TIOPD_ST_VBLANK_BIT = 0;
  localparam int TIOPD_ST_CONNECTED_BIT = 1;
  localparam int TIOPD_ST_CTS_BIT = 2;
  localparam int TIOPD_ST_HOOD_BIT = 3;
  localparam int TIOPD_ST_PRN_BUSY_BIT = 4;
  // printer status: bit 1 is presence
  localparam int TIOPD_PRN_PRESENT_BIT = 1;
  // reset values
  localparam logic [7:0] TIOPD_KBD_RESET = 8'h00;
  localparam logic TIOPD_NMI_MASK_RESET = 1'b0;
  // bell divider: last count, so sixteen hsync pulses per bell half period
  localparam logic [3:0] TIOPD_BELL_DIV = 4'hF;
  // modem disconnect hold time and its clock count
  localparam int TIOPD_CLK_MHZ = 100;
  localparam int TIOPD_DISC_MS = 2000;
  localparam int TIOPD_DISC_CYCLES = TIOPD_DISC_MS * 1000 * TIOPD_CLK_MHZ;
  localparam int TIOPD_DISC_W = 28;
endpackage

/* rtl/tiopd_top.sv */
// terminal i/o port decoder: selects, key scan, nmi mask, bell, modem lines
// assumes processor strobes are already synchronous to clk_in; the serial
// adapter itself (framing, parity, baud rate) is the selected part outside
`timescale 1ns/1ns

// Behaviour
// - a0h-a7h select serial adapter, bit2 splits
// - four read-only and four write-only ports
// - adapter frames one start, one/two stop
// - adapter parity and error status register
// - adapter baud rate programmable 110-9600
// - ready and request-to-send active after power-on
// - disconnect drops terminal ready about two seconds
// - transmit gated by clear-to-send unless ignored
// - rate select follows strap, default low
// - modem status lines active high at line
// - receive raises irq, status read clears
// - bus driver enabled except cfg ram/serial
// - port 80h reads eight key states
// - key address: four column bits plus three row bits
// - shift key state on each scan change
// - enabled counter divides hsync to bell
// - writes 88h-8fh load nmi mask from a0
// - port 90h reads vblank, modem, printer status
// - port 98h drives printer data, a1:a0 function
// - printer status bit1 low when absent
// - six 8k rom blocks, 4k jumper option
// - rom enabled early by opcode fetch
// - 00h-7fh select cfg ram with wait
module tiopd_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // processor bus
  input wire logic [15:0] addr_in,
  input wire logic [7:0] data_in,
  input wire logic io_request_n_in,
  input wire logic memory_request_n_in,
  input wire logic io_read_strobe_n_in,
  input wire logic io_write_strobe_n_in,
  input wire logic opcode_fetch_n_in,
  output logic [7:0] data_out,
  output logic data_drive_out,
  output logic wait_n_out,
  output logic maskable_irq_n_out,
  output logic nonmaskable_irq_n_out,
  // selects
  output logic serial_adapter_select_out,
  output logic serial_write_group_out,
  output logic cfg_ram_select_out,
  output logic bus_driver_enable_out,
  output logic bus_driver_to_cpu_out,
  output logic [5:0] rom_enable_out,
  // rom jumpers, one per socket: 1 = 4k part
  input wire logic [5:0] rom_small_part_in,
  // serial adapter side
  input wire logic adapter_irq_n_in,
  input wire logic adapter_tx_in,
  input wire logic cts_ignore_in,
  input wire logic rate_strap_in,
  output logic serial_transmit_line_out,
  // modem line side (after translators, high = active)
  input wire logic modem_connected_in,
  input wire logic clear_to_send_in,
  input wire logic loopback_hood_sense_in,
  output logic terminal_ready_out,
  output logic request_to_send_out,
  output logic modem_rate_select_out,
  // keyboard and video
  input wire logic key_active_in,
  input wire logic [2:0] scan_row_in,
  input wire logic hsync_in,
  input wire logic vblank_in,
  input wire logic nmi_source_n_in,
  output logic [6:0] key_address_out,
  output logic bell_out,
  output logic enhance_enable_out,
  output logic blink_rate_out,
  // printer
  input wire logic [7:0] printer_status_in,
  input wire logic printer_busy_in,
  output logic [7:0] printer_data_out,
  output logic [1:0] printer_function_out,
  output logic printer_strobe_n_out
);
  import tiopd_pkg::*;

  // reset synchroniser stages
  logic rst_meta_n;
  logic rst_n;

  // port decode helper: address in group of eight
  function automatic logic in_group(input logic [7:0] a, input logic [7:0] base);
    in_group = (a & TIOPD_GROUP_MASK) == base;
  endfunction

  // two-flop reset release
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // combinational cycle qualifiers
  logic io_cyc;
  logic io_rd;
  logic io_wr;
  logic [7:0] port;
  logic io_wr_q;
  logic io_rd_q;
  logic io_wr_edge;
  logic io_rd_edge;
  assign port = addr_in[7:0];
  assign io_cyc = !io_request_n_in;
  assign io_rd = io_cyc && !io_read_strobe_n_in;
  assign io_wr = io_cyc && !io_write_strobe_n_in;
  assign io_wr_edge = io_wr && !io_wr_q;
  assign io_rd_edge = io_rd && !io_rd_q;

  // strobe history, so each access acts once
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      io_wr_q <= 1'b0;
      io_rd_q <= 1'b0;
    end else begin
      io_wr_q <= io_wr;
      io_rd_q <= io_rd;
    end
  end

  // selects and driver control, registered for clean outputs
  logic next_cfg;
  logic next_ser;
  assign next_cfg = io_cyc && (port <= TIOPD_CFG_RAM_TOP);
  assign next_ser = io_cyc && in_group(port, TIOPD_SERIAL_ADAPTER_WINDOW);
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ram_select_out <= 1'b0;
      serial_adapter_select_out <= 1'b0;
      serial_write_group_out <= 1'b0;
      bus_driver_enable_out <= 1'b0;
      bus_driver_to_cpu_out <= 1'b0;
    end else begin
      cfg_ram_select_out <= next_cfg;
      serial_adapter_select_out <= next_ser;
      serial_write_group_out <= addr_in[TIOPD_SER_RW_BIT];
      bus_driver_enable_out <= io_cyc && !next_cfg && !next_ser;
      bus_driver_to_cpu_out <= !io_read_strobe_n_in;
    end
  end

  // one wait state per cfg ram access: wait drops for the first cycle only
  logic cfg_seen;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg_seen <= 1'b0;
      wait_n_out <= 1'b1;
    end else begin
      cfg_seen <= next_cfg;
      wait_n_out <= !(next_cfg && !cfg_seen);
    end
  end

  // rom enables: early from opcode fetch, else mreq with rd
  logic [2:0] rom_blk;
  logic rom_cyc;
  assign rom_blk = addr_in[15:13];
  assign rom_cyc = !memory_request_n_in &&
                   (!opcode_fetch_n_in || !io_read_strobe_n_in);
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rom_enable_out <= 6'h00;
    end else begin
      for (int i = 0; i < TIOPD_ROM_BLOCKS; i++) begin
        // block decode, upper 4k dead on small parts
        rom_enable_out[i] <= rom_cyc && (rom_blk == i[2:0]) &&
                             (rom_blk <= TIOPD_ROM_LAST_BLOCK) &&
                             !(rom_small_part_in[i] && addr_in[12]);
      end
    end
  end

  // nmi mask latch and gated nmi
  logic nmi_enable;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      nmi_enable <= TIOPD_NMI_MASK_RESET;
      nonmaskable_irq_n_out <= 1'b1;
    end else begin
      if (io_wr_edge && in_group(port, TIOPD_INTERRUPT_MASK_LATCH)) begin
        nmi_enable <= addr_in[0];
      end
      nonmaskable_irq_n_out <= !(nmi_enable && !nmi_source_n_in);
    end
  end

  // keyboard/display control and modem latch
  logic [7:0] kbd_ctl;
  logic disc_req;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      kbd_ctl <= TIOPD_KBD_RESET;
    end else if (io_wr_edge && in_group(port, TIOPD_KEYBOARD_DISPLAY_CONTROL)) begin
      kbd_ctl <= data_in;
    end
  end
  assign disc_req = io_wr_edge && in_group(port, TIOPD_MODEM_LATCH_PORT) &&
                    data_in[TIOPD_MDM_DISC_BIT];

  // key scan: shift one key state per scan row change
  logic [2:0] row_q;
  logic [7:0] key_shift;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      row_q <= 3'h0;
      key_shift <= 8'h00;
      key_address_out <= 7'h00;
    end else begin
      row_q <= scan_row_in;
      // column from port, row from scan count
      key_address_out <= {kbd_ctl[TIOPD_KBD_COL_LSB +: 4], scan_row_in};
      if (row_q != scan_row_in) begin
        key_shift <= {key_shift[6:0], key_active_in};
      end
    end
  end

  // bell: hsync edges divided down while enabled
  logic hs_q;
  logic [3:0] bell_cnt;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      hs_q <= 1'b0;
      bell_cnt <= 4'h0;
      bell_out <= 1'b0;
      enhance_enable_out <= 1'b0;
      blink_rate_out <= 1'b0;
    end else begin
      hs_q <= hsync_in;
      enhance_enable_out <= kbd_ctl[TIOPD_KBD_ENH_BIT];
      blink_rate_out <= kbd_ctl[TIOPD_KBD_BLINK_BIT];
      if (!kbd_ctl[TIOPD_KBD_BELL_BIT]) begin
        bell_cnt <= 4'h0;
        bell_out <= 1'b0;
      end else if (hsync_in && !hs_q) begin
        if (bell_cnt == TIOPD_BELL_DIV) begin
          bell_cnt <= 4'h0;
          bell_out <= !bell_out;
        end else begin
          bell_cnt <= bell_cnt + 4'h1;
        end
      end
    end
  end

  // modem control: ready lines, disconnect timer, rate select, cts gate
  logic [TIOPD_DISC_W-1:0] disc_cnt;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      disc_cnt <= '0;
      terminal_ready_out <= 1'b0;
      request_to_send_out <= 1'b0;
      modem_rate_select_out <= 1'b0;
      serial_transmit_line_out <= 1'b1;
    end else begin
      // hold ready low about two seconds
      if (disc_req) begin
        disc_cnt <= TIOPD_DISC_W'(TIOPD_DISC_CYCLES - 1);
      end else if (disc_cnt != '0) begin
        disc_cnt <= disc_cnt - 1'b1;
      end
      terminal_ready_out <= !disc_req && (disc_cnt == '0);
      request_to_send_out <= 1'b1;
      modem_rate_select_out <= rate_strap_in;
      // line idles mark while cts inactive and not ignored
      serial_transmit_line_out <= adapter_tx_in | !(clear_to_send_in | cts_ignore_in);
    end
  end

  // maskable irq: set by adapter event, cleared by serial status read
  logic irq_pending;
  logic ser_status_rd;
  assign ser_status_rd = io_rd_edge && in_group(port, TIOPD_SERIAL_ADAPTER_WINDOW) &&
                         !addr_in[TIOPD_SER_RW_BIT] && (port[1:0] == 2'h1);
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_pending <= 1'b0;
      maskable_irq_n_out <= 1'b1;
    end else begin
      // set wins over the clearing read
      if (!adapter_irq_n_in) begin
        irq_pending <= 1'b1;
      end else if (ser_status_rd) begin
        irq_pending <= 1'b0;
      end
      maskable_irq_n_out <= !irq_pending;
    end
  end

  // printer port: data driven continuously, strobe on write
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      printer_data_out <= 8'h00;
      printer_function_out <= 2'h0;
      printer_strobe_n_out <= 1'b1;
    end else begin
      if (io_wr_edge && in_group(port, TIOPD_PRINTER_DATA_PORT)) begin
        printer_data_out <= data_in;
        printer_function_out <= addr_in[1:0];
      end
      printer_strobe_n_out <= !(io_wr && in_group(port, TIOPD_PRINTER_DATA_PORT));
    end
  end

  // read mux for tbus ports; status taken high-active
  logic [7:0] next_rd;
  always_comb begin
    next_rd = 8'h00;
    if (in_group(port, TIOPD_KEY_STATE_READ)) begin
      next_rd = key_shift;
    end else if (in_group(port, TIOPD_SYSTEM_STATUS_READ)) begin
      next_rd[TIOPD_ST_VBLANK_BIT] = vblank_in;
      next_rd[TIOPD_ST_CONNECTED_BIT] = modem_connected_in;
      next_rd[TIOPD_ST_CTS_BIT] = clear_to_send_in;
      next_rd[TIOPD_ST_HOOD_BIT] = loopback_hood_sense_in;
      next_rd[TIOPD_ST_PRN_BUSY_BIT] = printer_busy_in;
    end else if (in_group(port, TIOPD_PRINTER_DATA_PORT)) begin
      // presence bit passes as seen on the connector
      next_rd = printer_status_in;
    end
  end

  // registered read data and drive flag
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 8'h00;
      data_drive_out <= 1'b0;
    end else begin
      data_out <= next_rd;
      data_drive_out <= io_rd && !next_cfg && !next_ser;
    end
  end
endmodule

/* verification/tiopd_checker.sv */
// checker for the port decoder: select timing, masks, modem and rom lines
// assumes it is bound to tiopd_top and sees only that module's ports
`timescale 1ns/1ns
module tiopd_checker (
  // clock, reset and processor bus
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [15:0] addr_in,
  input wire logic io_request_n_in,
  input wire logic memory_request_n_in,
  input wire logic io_write_strobe_n_in,
  input wire logic io_read_strobe_n_in,
  input wire logic opcode_fetch_n_in,
  // side inputs
  input wire logic [5:0] rom_small_part_in,
  input wire logic adapter_irq_n_in,
  input wire logic adapter_tx_in,
  input wire logic cts_ignore_in,
  input wire logic clear_to_send_in,
  // watched outputs
  input wire logic serial_adapter_select_out,
  input wire logic serial_write_group_out,
  input wire logic bus_driver_enable_out,
  input wire logic bus_driver_to_cpu_out,
  input wire logic cfg_ram_select_out,
  input wire logic wait_n_out,
  input wire logic maskable_irq_n_out,
  input wire logic nonmaskable_irq_n_out,
  input wire logic [5:0] rom_enable_out,
  input wire logic serial_transmit_line_out,
  input wire logic terminal_ready_out,
  input wire logic request_to_send_out
);
  // port group: eight ports share one decode
  logic [4:0] grp;
  assign grp = addr_in[7:3];
  // one domain, so clock and disable are set once
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  AST_SER_SEL: assert property (
    !io_request_n_in && grp == 5'h14 |=> serial_adapter_select_out
    && serial_write_group_out == $past(addr_in[2])) else $error("serial select wrong");
  AST_DRV_EN: assert property (
    !io_request_n_in |=> bus_driver_enable_out == ($past(addr_in[7]) && $past(grp) != 5'h14))
    else $error("bus driver enable wrong");
  AST_DRV_DIR: assert property (
    !io_request_n_in |=> bus_driver_to_cpu_out == !$past(io_read_strobe_n_in))
    else $error("bus driver direction wrong");
  AST_CFG_SEL: assert property (
    !io_request_n_in |=> cfg_ram_select_out == !$past(addr_in[7]))
    else $error("cfg select wrong");
  AST_CFG_WAIT: assert property (
    $fell(io_request_n_in) && !addr_in[7] |=> !wait_n_out ##1 wait_n_out)
    else $error("cfg wait wrong");
  AST_NMI_OFF: assert property (
    $fell(io_request_n_in | io_write_strobe_n_in) && grp == 5'h11 && !addr_in[0]
    |-> ##3 nonmaskable_irq_n_out) else $error("nmi not masked");
  AST_RST_STATE: assert property (
    $rose(rstn_in) |-> nonmaskable_irq_n_out ##[1:4] (terminal_ready_out && request_to_send_out))
    else $error("reset state wrong");
  // mark is forced whenever the far end withholds clear-to-send and cts_ignore_in is low
  AST_TX_GATE: assert property (
    1'b1 |=> serial_transmit_line_out == ($past(adapter_tx_in)
    || !$past(clear_to_send_in || cts_ignore_in))) else $error("tx gating wrong");
  AST_IRQ_SET: assert property (
    !adapter_irq_n_in |-> ##[2:3] !maskable_irq_n_out) else $error("irq not raised");
  // opcode fetches and plain memory reads both enable the block
  AST_ROM_EN: assert property (
    !memory_request_n_in && !(opcode_fetch_n_in && io_read_strobe_n_in)
    && addr_in[15:13] < 3'h6
    |=> rom_enable_out == ($past(addr_in[12] && rom_small_part_in[addr_in[15:13]])
    ? 6'h00 : 6'h01 << $past(addr_in[15:13]))) else $error("rom enable wrong");
  // main scenarios reached
  COV_NMI: cover property (!nonmaskable_irq_n_out);
  COV_IRQ: cover property (!maskable_irq_n_out);
  COV_WAIT: cover property (!wait_n_out);
  COV_ROM: cover property (rom_enable_out != 6'h00);
endmodule
bind tiopd_top tiopd_checker u_chk (.*);

/* verification/tiopd_cpu_model.sv */
// processor model: runs i/o and memory cycles on the decoder's bus
// assumes the decoder samples strobes on the rising edge of clk_in
`timescale 1ns/1ns
module tiopd_cpu_model (
  // clock
  input wire logic clk_in,
  // bus towards the decoder
  output logic [15:0] addr_out,
  output logic [7:0] data_out,
  output logic io_request_n_out,
  output logic memory_request_n_out,
  output logic io_read_strobe_n_out,
  output logic io_write_strobe_n_out,
  output logic opcode_fetch_n_out
);
  // strobes packed as iorq, mreq, rd, wr, m1
  logic [4:0] strb = 5'h1F;
  assign {io_request_n_out, memory_request_n_out, io_read_strobe_n_out,
    io_write_strobe_n_out, opcode_fetch_n_out} = strb;
  initial addr_out = 16'h0000;
  initial data_out = 8'h00;
  // one cycle: set after a falling edge, held over three rising edges
  task automatic cyc(input logic [4:0] s, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    data_out = d;
    strb = s;
    // fixed hold outlasts the single cfg wait state
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    strb = 5'h1F;
    // released bus must not keep the old value
    addr_out = ~a;
    data_out = ~d;
  endtask
endmodule

/* verification/tiopd_top_tb.sv */
// self-checking bench for the port decoder with a processor model
// assumes the checker binds itself; reads are checked from a queue
`timescale 1ns/1ns
module tiopd_top_tb;
  import tiopd_pkg::*;
  logic clk_in, rstn_in, data_drive_out, wait_n_out, maskable_irq_n_out;
  logic [15:0] addr_in;
  logic [7:0] data_in, data_out, printer_status_in, printer_data_out;
  logic io_request_n_in, memory_request_n_in, io_read_strobe_n_in, io_write_strobe_n_in;
  logic opcode_fetch_n_in, nonmaskable_irq_n_out, serial_adapter_select_out;
  logic serial_write_group_out, cfg_ram_select_out, bus_driver_enable_out;
  logic bus_driver_to_cpu_out, serial_transmit_line_out, bell_out, printer_strobe_n_out;
  logic [5:0] rom_enable_out, rom_small_part_in;
  logic adapter_irq_n_in, adapter_tx_in, cts_ignore_in, rate_strap_in, hsync_in;
  logic modem_connected_in, clear_to_send_in, loopback_hood_sense_in, vblank_in;
  logic terminal_ready_out, request_to_send_out, modem_rate_select_out, key_active_in;
  logic nmi_source_n_in, printer_busy_in, enhance_enable_out, blink_rate_out, drv_d;
  logic [2:0] scan_row_in;
  logic [6:0] key_address_out;
  logic [1:0] printer_function_out;
  logic [31:0] r;
  logic [7:0] exp_q[$];
  int errors, checks_done, seed, i, k;
  tiopd_top u_dut (.*);
  tiopd_cpu_model u_cpu (.clk_in(clk_in), .addr_out(addr_in), .data_out(data_in),
    .io_request_n_out(io_request_n_in), .memory_request_n_out(memory_request_n_in),
    .io_read_strobe_n_out(io_read_strobe_n_in), .io_write_strobe_n_out(io_write_strobe_n_in),
    .opcode_fetch_n_out(opcode_fetch_n_in));
  always #5 clk_in = ~clk_in;
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // a read notes its expected byte, the watcher compares it later
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    u_cpu.cyc(5'h0B, {8'h00, a}, 8'h00);
  endtask
  // watcher: bus-driver read data taken as it first appears
  always @(negedge clk_in) begin
    if (data_drive_out === 1'b1 && drv_d !== 1'b1) begin
      if (exp_q.size() == 0) chk("stray read", 8'h00, 8'hFF);
      else chk("read data", data_out, exp_q.pop_front());
    end
    drv_d = data_drive_out;
  end
  // hang guard, far beyond the normal run
  initial begin
    #300000;
    errors++;
    complete_run;
  end
  initial begin
    {seed, errors, checks_done, drv_d, clk_in, rstn_in} = {32'd22, 64'd0, 3'h0};
    {adapter_irq_n_in, adapter_tx_in, nmi_source_n_in, cts_ignore_in, rate_strap_in} = 5'h1C;
    {key_active_in, hsync_in, scan_row_in, vblank_in, modem_connected_in} = 7'h00;
    {clear_to_send_in, loopback_hood_sense_in, printer_busy_in} = 3'h0;
    {printer_status_in, rom_small_part_in} = 14'h0000;
    repeat (2) @(negedge clk_in);
    rstn_in = 1'b1;
    repeat (4) @(negedge clk_in);
    chk("ready lines", {6'h00, terminal_ready_out, request_to_send_out}, 8'h03);
    chk("nmi idle", 8'(nonmaskable_irq_n_out), 8'h01);
    $display("test reset done");
    // column a, bell, enhance and blink on
    u_cpu.cyc(5'h0D, {8'h00, TIOPD_KEYBOARD_DISPLAY_CONTROL}, 8'h7A);
    for (k = 0; k < 2; k++) begin
      key_active_in = k[0];
      for (i = 0; i < 8; i++) begin
        @(negedge clk_in);
        scan_row_in = scan_row_in + 3'h1;
        repeat (2) @(negedge clk_in);
      end
      rd(TIOPD_KEY_STATE_READ, k[0] ? 8'hFF : 8'h00);
    end
    chk("key address", {1'b0, key_address_out}, {1'b0, 4'hA, scan_row_in});
    chk("enhance blink", {6'h00, enhance_enable_out, blink_rate_out}, 8'h03);
    for (i = 1; i <= 16; i++) begin
      @(negedge clk_in);
      hsync_in = 1'b1;
      repeat (2) @(negedge clk_in);
      hsync_in = 1'b0;
      repeat (2) @(negedge clk_in);
      if (i >= 15) chk("bell", 8'(bell_out), 8'(i / 16));
    end
    $display("test keyboard done");
    for (i = 0; i < 6; i++) begin
      r = $random(seed);
      {printer_busy_in, loopback_hood_sense_in, clear_to_send_in} = r[4:2];
      {modem_connected_in, vblank_in} = r[1:0];
      printer_status_in = i[0] ? r[15:8] | 8'h02 : r[15:8] & 8'hFD;
      rd(TIOPD_SYSTEM_STATUS_READ, {3'h0, r[4:0]});
      rd(TIOPD_PRINTER_DATA_PORT, printer_status_in);
    end
    $display("test status done");
    nmi_source_n_in = 1'b0;
    u_cpu.cyc(5'h0D, 16'h008F, 8'h00);
    repeat (2) @(negedge clk_in);
    chk("nmi on", 8'(nonmaskable_irq_n_out), 8'h00);
    u_cpu.cyc(5'h0D, 16'h008A, 8'h00);
    repeat (2) @(negedge clk_in);
    chk("nmi off", 8'(nonmaskable_irq_n_out), 8'h01);
    adapter_irq_n_in = 1'b0;
    @(negedge clk_in);
    adapter_irq_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    chk("irq raised", 8'(maskable_irq_n_out), 8'h00);
    u_cpu.cyc(5'h0B, 16'h00A1, 8'h00);
    u_cpu.cyc(5'h0D, 16'h00A4, 8'h55);
    chk("irq cleared", 8'(maskable_irq_n_out), 8'h01);
    rate_strap_in = 1'b1;
    u_cpu.cyc(5'h0D, {8'h00, TIOPD_MODEM_LATCH_PORT}, 8'h01);
    repeat (6) @(negedge clk_in);
    chk("ready dropped", 8'(terminal_ready_out), 8'h00);
    chk("rate select", 8'(modem_rate_select_out), 8'h01);
    repeat (40) begin
      @(negedge clk_in);
      r = $random(seed);
      {adapter_tx_in, clear_to_send_in, cts_ignore_in} = r[2:0];
    end
    $display("test interrupts and modem done");
    for (i = 0; i < 31; i++) begin
      r = $random(seed);
      u_cpu.cyc(5'h0D, i < 30 ? 16'h0098 : 16'h009B, r[7:0]);
      chk("printer data", printer_data_out, r[7:0]);
      chk("printer function", 8'(printer_function_out), i < 30 ? 8'h00 : 8'h03);
      // strobe still low: write strobe was still asserted at the final rising edge
      chk("printer strobe", 8'(printer_strobe_n_out), 8'h00);
    end
    // rom fetches and reads, then cfg ram access
    for (i = 0; i < 16; i++) begin
      r = $random(seed);
      rom_small_part_in = r[5:0];
      u_cpu.cyc(r[6] ? 5'h12 : 5'h13, {i[3:0], r[23:12]}, 8'h00);
      u_cpu.cyc(r[7] ? 5'h0B : 5'h0D, {9'h000, r[14:8]}, r[7:0]);
    end
    $display("test printer and rom done");
    chk("reads left", 8'(exp_q.size()), 8'h00);
    complete_run;
  end
endmodule
